// >>> src/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
// ****************************************
// Register map (word index on the plain port)
// ****************************************
`define SSR_AW 3
`define SSR_OFS_RXSC 3'h0
`define SSR_OFS_RXD 3'h1
`define SSR_OFS_TXSC 3'h2
`define SSR_OFS_BAUD 3'h3
`define SSR_OFS_DIVH 3'h4
`define SSR_OFS_DIVL 3'h5
`define SSR_OFS_TXD 3'h6
`define SSR_OFS_IRQ 3'h7
// ****************************************
// Field positions
// ****************************************
`define SSR_B_SERIAL_PORT_ENABLE 7
`define SSR_B_RX9 6
`define SSR_B_SINGLE_WORD_RECEIVE_ENABLE 5
`define SSR_B_CONTINUOUS_RECEIVE_ENABLE 4
`define SSR_B_FRAMING_ERROR_FLAG 2
`define SSR_B_OVERRUN_ERROR_FLAG 1
`define SSR_B_RECEIVED_NINTH_BIT 0
`define SSR_B_CLOCK_SOURCE_MASTER 7
`define SSR_B_TX9 6
`define SSR_B_TRANSMIT_ENABLE 5
`define SSR_B_SYNC 4
`define SSR_B_TRMT 1
`define SSR_B_TRANSMIT_NINTH_BIT 0
`define SSR_B_CKP 4
`define SSR_B_DIVIDER_WIDTH_OPTION 3
`define SSR_B_RCF 0
`define SSR_B_TXF 1
`define SSR_B_RCIE 4
`define SSR_B_TXIE 5
// ****************************************
// Counts and reset values
// ****************************************
`define SSR_BITS8 4'h7
`define SSR_BITS9 4'h8
`define SSR_RST8 8'h00
`define SSR_RST16 16'h0000
`endif

// >>> src/ssr_pkg.sv
`include "ssr_cfg.svh"
package ssr_pkg;
   typedef logic [`SSR_AW-1:0] ssr_addr_t;
   typedef enum logic [1:0] {SSR_IDLE, SSR_RX, SSR_TX} ssr_fsm_t;
   typedef struct packed {
      logic ck_s1, ck_s2, ck_d, dt_s1, dt_s2;
      ssr_fsm_t fsm;
      logic serial_port_enable, rx9, single_word_receive_enable, continuous_receive_enable, overrun_error_flag, received_ninth_bit;
      logic [7:0] rxdata;
      logic rc_flag;
      logic clock_source_master, tx9, transmit_enable, sync, transmit_ninth_bit, clock_idle_polarity, divider_width_option;
      logic [7:0] div_hi, div_lo, txbuf;
      logic txbuf_full, tx9_buf, tsr_busy;
      logic [8:0] transmit_shift_register, receive_shift_register;
      logic rcie, txie;
      logic [15:0] brg_cnt;
      logic sck;
      logic [3:0] bitcnt;
      logic dt_out;
      logic [7:0] rdata;
   } ssr_state_t;
endpackage

// >>> src/ssr_top.sv
`timescale 1ns/1ps
// Behaviour
// - With clocked master mode on, setting either receive enable starts reception.
// - Incoming data is sampled on each falling shift-clock edge.
// - Single-word enable receives exactly one word, then stops.
// - Continuous enable keeps receiving words until software clears it or an overrun occurs.
// - Both enables set behaves as continuous reception.
// - Word complete sets receive flag; interrupt only when its enable is set.
// - Status shows ninth bit and overrun error; software reads it before data.
// - The lower received byte is presented in the receive data register.
// - Clearing continuous enable clears pending receive error.
// - Clearing master clock source selects slave mode with external shift clock.
// - Slave mode shifts data in or out during any low-power state.
// - Two queued slave words: first shifts out, second buffered, empty flag clear.
// - After first word, buffered word moves to shifter, then empty flag sets.
// - Empty flag with its enable set raises an interrupt that wakes the core.
// - In slave reception the single-word enable is ignored.
// - Continuous slave reception in low power still completes and transfers words.
// - Half duplex: transmit and receive never run at the same time.
// - Clock polarity bit selects high or low idle level of shift clock.
module ssr_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire ssr_pkg::ssr_addr_t addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Core state
   input wire logic low_power,
   // Shift clock pin
   input wire logic ck_in,
   output logic ck_out,
   output logic ck_oe_n,
   // Serial data pin
   input wire logic dt_in,
   output logic dt_out,
   output logic dt_oe_n,
   // Requests to the interrupt controller
   output logic rx_irq,
   output logic tx_irq
);
   import ssr_pkg::*;

   ssr_state_t q, d;

   // ****************************************
   // Edge detection and mode decode
   // ****************************************
   logic master, active, rx_want, sck_now, sck_prev, fall_ev, rise_ev;
   logic word_done, go_rx, load_tsr, brg_tick, rd_data, wr_rxsc;
   logic [3:0] nbits;
   logic [15:0] reload;
   logic [8:0] rsr_next;

   assign master = q.clock_source_master;
   assign active = q.serial_port_enable & q.sync;
   // Slave ignores the single-word enable
   assign rx_want = q.continuous_receive_enable | (q.single_word_receive_enable & master);
   assign nbits = q.rx9 ? `SSR_BITS9 : `SSR_BITS8;
   assign reload = q.divider_width_option ? {q.div_hi, q.div_lo} : {`SSR_RST8, q.div_lo};
   // Core clock halts in low power, so the master divider pauses too
   assign brg_tick = master & ~low_power & (q.brg_cnt == `SSR_RST16);
   // Slave clock comes through the synchroniser, polarity removed
   assign sck_now = master ? q.sck : (q.ck_s2 ^ q.clock_idle_polarity);
   assign sck_prev = q.ck_d ^ q.clock_idle_polarity;
   assign fall_ev = master ? (brg_tick & q.sck & q.fsm == SSR_RX)
                           : (sck_prev & ~sck_now);
   assign rise_ev = ~master & ~sck_prev & sck_now;
   assign rsr_next = {q.dt_s2, q.receive_shift_register[8:1]};
   assign word_done = (q.fsm == SSR_RX) & fall_ev & (q.bitcnt == nbits);
   assign go_rx = active & rx_want & ~q.overrun_error_flag & ~q.tsr_busy;
   assign load_tsr = active & ~master & q.transmit_enable & q.txbuf_full & ~q.tsr_busy
                     & ~rx_want & (q.fsm == SSR_IDLE);
   assign rd_data = rd & (addr == `SSR_OFS_RXD);
   assign wr_rxsc = wr & (addr == `SSR_OFS_RXSC);

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      d = q;
      d.ck_s1 = ck_in;
      d.ck_s2 = q.ck_s1;
      d.ck_d = q.ck_s2;
      d.dt_s1 = dt_in;
      d.dt_s2 = q.dt_s1;
      d.rdata = `SSR_RST8;

      // Divider runs only in the receive state, in slave mode as well as master
      if (brg_tick || q.fsm != SSR_RX) begin
         d.brg_cnt = reload;
      end else if (!low_power) begin
         d.brg_cnt = q.brg_cnt - 16'h0001;
      end

      unique case (q.fsm)
         SSR_IDLE: begin
            d.sck = 1'b0;
            d.bitcnt = 4'h0;
            if (go_rx) begin
               d.fsm = SSR_RX;
            end else if (load_tsr) begin
               d.fsm = SSR_TX;
               d.transmit_shift_register = {q.tx9_buf, q.txbuf};
               d.tsr_busy = 1'b1;
               d.txbuf_full = 1'b0;
               d.dt_out = q.txbuf[0];
            end
         end
         SSR_RX: begin
            if (master && brg_tick) begin
               d.sck = ~q.sck;
            end
            if (fall_ev) begin
               d.receive_shift_register = rsr_next;
               d.bitcnt = q.bitcnt + 4'h1;
            end
            if (word_done) begin
               d.bitcnt = 4'h0;
               if (q.rc_flag && !rd_data) begin
                  d.overrun_error_flag = 1'b1; // Unread word held, new one dropped
               end else begin
                  d.rc_flag = 1'b1;
                  d.rxdata = q.rx9 ? rsr_next[7:0] : rsr_next[8:1];
                  d.received_ninth_bit = q.rx9 & rsr_next[8];
               end
               if (!q.continuous_receive_enable) begin
                  d.single_word_receive_enable = 1'b0;
                  d.fsm = SSR_IDLE;
               end else if (q.rc_flag && !rd_data) begin
                  d.fsm = SSR_IDLE;
               end
            end else if (!active || !rx_want) begin
               d.fsm = SSR_IDLE;
               d.sck = 1'b0;
               d.bitcnt = 4'h0;
            end
         end
         SSR_TX: begin
            // Data changes on rising edges; the partner samples on falling ones
            if (rise_ev && q.bitcnt != 4'h0) begin
               d.dt_out = q.transmit_shift_register[1];
               d.transmit_shift_register = {1'b0, q.transmit_shift_register[8:1]};
            end
            if (fall_ev) begin
               d.bitcnt = q.bitcnt + 4'h1;
               if (q.bitcnt == (q.tx9 ? `SSR_BITS9 : `SSR_BITS8)) begin
                  d.bitcnt = 4'h0;
                  d.tsr_busy = 1'b0;
                  d.fsm = SSR_IDLE;
               end
            end
            if (!active || !q.transmit_enable || master) begin
               d.tsr_busy = 1'b0;
               d.bitcnt = 4'h0;
               d.fsm = SSR_IDLE;
            end
         end
      endcase

      // Register writes
      if (wr) begin
         unique case (addr)
            `SSR_OFS_RXSC: begin
               d.serial_port_enable = wdata[`SSR_B_SERIAL_PORT_ENABLE];
               d.rx9 = wdata[`SSR_B_RX9];
               d.single_word_receive_enable = wdata[`SSR_B_SINGLE_WORD_RECEIVE_ENABLE];
               d.continuous_receive_enable = wdata[`SSR_B_CONTINUOUS_RECEIVE_ENABLE];
               if (!wdata[`SSR_B_CONTINUOUS_RECEIVE_ENABLE]) begin
                  d.overrun_error_flag = 1'b0;
               end
            end
            `SSR_OFS_TXSC: begin
               d.clock_source_master = wdata[`SSR_B_CLOCK_SOURCE_MASTER];
               d.tx9 = wdata[`SSR_B_TX9];
               d.transmit_enable = wdata[`SSR_B_TRANSMIT_ENABLE];
               d.sync = wdata[`SSR_B_SYNC];
               d.transmit_ninth_bit = wdata[`SSR_B_TRANSMIT_NINTH_BIT];
            end
            `SSR_OFS_BAUD: begin
               d.clock_idle_polarity = wdata[`SSR_B_CKP];
               d.divider_width_option = wdata[`SSR_B_DIVIDER_WIDTH_OPTION];
            end
            `SSR_OFS_DIVH: d.div_hi = wdata;
            `SSR_OFS_DIVL: d.div_lo = wdata;
            `SSR_OFS_TXD: begin
               // A write into a full buffer overwrites the queued word
               d.txbuf = wdata;
               d.tx9_buf = q.transmit_ninth_bit;
               d.txbuf_full = 1'b1;
            end
            `SSR_OFS_IRQ: begin
               d.rcie = wdata[`SSR_B_RCIE];
               d.txie = wdata[`SSR_B_TXIE];
            end
            default: ;
         endcase
      end

      // A word landing in the same cycle as the read keeps the flag set
      if (rd_data && !(word_done && !q.overrun_error_flag)) begin
         d.rc_flag = 1'b0;
      end

      if (rd) begin
         unique case (addr)
            `SSR_OFS_RXSC: d.rdata = {q.serial_port_enable, q.rx9, q.single_word_receive_enable, q.continuous_receive_enable, 1'b0,
                                      1'b0, q.overrun_error_flag, q.received_ninth_bit};
            `SSR_OFS_RXD: d.rdata = q.rxdata;
            `SSR_OFS_TXSC: d.rdata = {q.clock_source_master, q.tx9, q.transmit_enable, q.sync, 1'b0,
                                      1'b0, ~q.tsr_busy, q.transmit_ninth_bit};
            `SSR_OFS_BAUD: d.rdata = {3'h0, q.clock_idle_polarity, q.divider_width_option, 3'h0};
            `SSR_OFS_DIVH: d.rdata = q.div_hi;
            `SSR_OFS_DIVL: d.rdata = q.div_lo;
            `SSR_OFS_TXD: d.rdata = q.txbuf;
            `SSR_OFS_IRQ: d.rdata = {2'h0, q.txie, q.rcie, 2'h0,
                                     ~q.txbuf_full, q.rc_flag};
            default: d.rdata = `SSR_RST8;
         endcase
      end

      if (!q.serial_port_enable) begin
         d.fsm = SSR_IDLE;
         d.tsr_busy = 1'b0;
         d.sck = 1'b0;
         d.bitcnt = 4'h0;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata = q.rdata;
   // Idle level follows the polarity bit
   assign ck_out = q.sck ^ q.clock_idle_polarity;
   assign ck_oe_n = ~(active & master);
   assign dt_out = q.dt_out;
   assign dt_oe_n = ~((q.fsm == SSR_TX) & active & ~master);
   assign rx_irq = q.rc_flag & q.rcie;
   assign tx_irq = ~q.txbuf_full & q.txie;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   chk_rx_start_go: assert property (
      q.fsm == SSR_IDLE && go_rx && q.serial_port_enable |=> q.fsm == SSR_RX)
      else $error("reception did not start");
   chk_fall_sample_bit: assert property (
      q.fsm == SSR_RX && fall_ev && q.serial_port_enable |=> q.receive_shift_register[8] == $past(q.dt_s2))
      else $error("data not sampled on falling edge");
   chk_single_word_stop: assert property (
      word_done && !q.continuous_receive_enable && !wr |=> q.fsm == SSR_IDLE && !q.single_word_receive_enable)
      else $error("single word did not stop");
   chk_cont_keep_going: assert property (
      word_done && q.continuous_receive_enable && !q.rc_flag && !wr |=> q.fsm == SSR_RX)
      else $error("continuous reception stopped");
   chk_flag_on_done: assert property (
      word_done && !q.overrun_error_flag && !q.rc_flag |=> q.rc_flag && q.bitcnt == 4'h0)
      else $error("receive flag not set after word");
   chk_rx_irq_cause: assert property (
      $rose(rx_irq) |-> q.rcie && $past(q.fsm == SSR_RX || !q.rcie))
      else $error("receive interrupt without cause");
   chk_overrun_error_flag_clear_continuous_receive_enable: assert property (
      wr_rxsc && !wdata[`SSR_B_CONTINUOUS_RECEIVE_ENABLE] |=> !q.overrun_error_flag)
      else $error("error not cleared by continuous enable");
   chk_half_duplex_pin: assert property (
      !dt_oe_n |-> q.tsr_busy && q.fsm != SSR_RX && !master)
      else $error("data driven while receiving");
   chk_idle_clock_level: assert property (
      q.fsm == SSR_IDLE && active && master |=> ck_out == q.clock_idle_polarity || q.fsm == SSR_RX)
      else $error("shift clock idle level wrong");
   chk_read_clears_flag: assert property (
      rd_data && !word_done |=> !q.rc_flag)
      else $error("receive flag not cleared by read");
   chk_tx_load_flag: assert property (
      load_tsr && !(wr && addr == `SSR_OFS_TXD) |=> !q.txbuf_full && q.tsr_busy)
      else $error("empty flag not set after load");
   chk_slave_single_off: assert property (
      q.fsm == SSR_IDLE && !master && !q.continuous_receive_enable |=> q.fsm != SSR_RX)
      else $error("slave reception without continuous enable");

   cov_single_word: cover property (word_done && !q.continuous_receive_enable && master);
   cov_cont_two_words: cover property (word_done && q.continuous_receive_enable ##[1:1000] word_done);
   cov_slave_tx_queue: cover property (load_tsr ##1 (wr && addr == `SSR_OFS_TXD));
   cov_overrun: cover property ($rose(q.overrun_error_flag));
   cov_nine_bit_word: cover property (word_done && q.rx9);

   // ****************************************
   // Pin and flag checks
   // ****************************************
   // An eight-bit word must not leave a stale ninth bit behind
   chk_ninth_bit_clear: assert property (
      word_done && !q.rx9 && !q.rc_flag |=> !q.received_ninth_bit)
      else $error("ninth bit set in eight-bit mode");
   chk_rx_data_lands: assert property (
      word_done && !q.rx9 && !q.rc_flag |=> q.rxdata[7] == $past(q.dt_s2))
      else $error("last received bit not in data register");
   chk_rx_irq_gated: assert property (
      !q.rcie |-> !rx_irq)
      else $error("receive interrupt while disabled");
   chk_tx_irq_level: assert property (
      q.txie && !q.txbuf_full |-> tx_irq)
      else $error("transmit interrupt missing");
   chk_tx_queue_full: assert property (
      wr && addr == `SSR_OFS_TXD |=> q.txbuf_full)
      else $error("queued word not held");
   chk_no_tx_in_rx: assert property (
      q.fsm == SSR_RX |-> !q.tsr_busy)
      else $error("shifter busy while receiving");
   chk_idle_clock_low: assert property (
      q.fsm == SSR_IDLE |-> !q.sck)
      else $error("internal shift clock runs while idle");
   chk_slave_clock_free: assert property (
      !master |-> ck_oe_n)
      else $error("clock pin driven in slave mode");
   chk_lp_tx_shift: assert property (
      low_power && q.fsm == SSR_TX && rise_ev && q.bitcnt != 4'h0 |=> q.dt_out == $past(q.transmit_shift_register[1]))
      else $error("slave transmit stalled in low power");

endmodule // ssr_top

// >>> tb/ssr_partner.sv
`timescale 1ns/1ps
module ssr_partner (
   // Device pin drives
   input wire logic ck_out,
   input wire logic ck_oe_n,
   input wire logic dt_out,
   input wire logic dt_oe_n,
   // Resolved pin levels
   output logic ck_in,
   output logic dt_in
);
   logic p_ck = 1'h0;
   logic p_dt = 1'h0;
   logic p_dt_en = 1'h0;
   logic bq[$];
   // ****************************************
   // Pin resolution
   // ****************************************
   // A released data line shows the inverse of its last level, so stale bits never pass
   assign ck_in = !ck_oe_n ? ck_out : p_ck;
   assign dt_in = !dt_oe_n ? dt_out : (p_dt_en ? p_dt : ~p_dt);
   // ****************************************
   // Master receive responder
   // ****************************************
   task automatic load(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         bq.push_back(w[i]);
      end
   endtask
   // Next bit leaves on the rising edge, half a period ahead of the sampling edge
   always @(posedge ck_in) begin
      if (!ck_oe_n) begin
         p_dt_en = 1'h1;
         p_dt = (bq.size() > 0) ? bq.pop_front() : 1'($urandom);
      end
   end
   // ****************************************
   // Slave frames, clock only runs inside them
   // ****************************************
   task automatic xfer(input logic [8:0] w, input int n, output logic [8:0] got);
      got = 9'h000;
      p_dt_en = 1'h1;
      for (int i = 0; i < n; i++) begin
         p_dt = w[i];
         #12 p_ck = 1'h1;
         #24 got[i] = dt_in;
         p_ck = 1'h0;
         #12;
      end
      p_dt_en = 1'h0;
   endtask
endmodule // ssr_partner

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module tb_top;
   import ssr_pkg::*;
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   ssr_addr_t addr = '0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic low_power = 1'h0;
   logic [7:0] rdata;
   logic ck_in, ck_out, ck_oe_n, dt_in, dt_out, dt_oe_n, rx_irq, tx_irq;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic rd_seen = 1'h0;
   logic bad;
   string nq[$];
   logic [7:0] eq[$];
   logic [7:0] mq[$];
   logic [7:0] m, b0, b1;
   logic [8:0] w0, w1, got;
   always #2.5 core_clk = ~core_clk;
   ssr_top DUT (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .low_power(low_power), .ck_in(ck_in), .ck_out(ck_out),
      .ck_oe_n(ck_oe_n), .dt_in(dt_in), .dt_out(dt_out), .dt_oe_n(dt_oe_n),
      .rx_irq(rx_irq), .tx_irq(tx_irq));
   ssr_partner PAR (.ck_out(ck_out), .ck_oe_n(ck_oe_n), .dt_out(dt_out),
      .dt_oe_n(dt_oe_n), .ck_in(ck_in), .dt_in(dt_in));
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr_reg(input ssr_addr_t a, input logic [7:0] d);
      @(posedge core_clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'h0;
   endtask
   task automatic rd_exp(input ssr_addr_t a, input logic [7:0] e, input logic [7:0] k,
                         input string name);
      nq.push_back(name);
      eq.push_back(e);
      mq.push_back(k);
      @(posedge core_clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'h0;
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      reset <= 1'h1;
      low_power <= 1'h0;
      PAR.bq.delete();
      repeat (3) @(posedge core_clk);
      reset <= 1'h0;
   endtask
   task automatic wait_rx();
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 400 && rx_irq !== 1'h1; i++) @(posedge core_clk);
      check("rx_irq", {8'h00, rx_irq}, 9'h001);
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_seen && eq.size() > 0) begin
         m = mq.pop_front();
         check(nq.pop_front(), {1'h0, rdata & m}, {1'h0, eq.pop_front() & m});
      end
      rd_seen <= rd;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         print_verdict();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h79F8));
      do_reset();
      rd_exp(`SSR_OFS_RXSC, 8'h00, 8'hFF, "rx_status");
      rd_exp(`SSR_OFS_IRQ, 8'h02, 8'hFF, "flags");
      check("ck_oe_n", {8'h00, ck_oe_n}, 9'h001);
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      wr_reg(`SSR_OFS_DIVH, b0);
      wr_reg(`SSR_OFS_DIVL, b1);
      wr_reg(`SSR_OFS_RXD, b0);
      rd_exp(`SSR_OFS_DIVH, b0, 8'hFF, "div_hi");
      rd_exp(`SSR_OFS_DIVL, b1, 8'hFF, "div_lo");
      rd_exp(`SSR_OFS_RXD, 8'h00, 8'hFF, "rx_data_ro");
      // Idle level follows the polarity bit
      wr_reg(`SSR_OFS_TXSC, 8'h90);
      wr_reg(`SSR_OFS_RXSC, 8'h80);
      wr_reg(`SSR_OFS_BAUD, 8'h10);
      repeat (3) @(posedge core_clk);
      check("ck_idle_hi", {7'h00, ck_out, ck_oe_n}, 9'h002);
      wr_reg(`SSR_OFS_BAUD, 8'h00);
      repeat (3) @(posedge core_clk);
      check("ck_idle_lo", {8'h00, ck_out}, 9'h000);
      // Master single word
      wr_reg(`SSR_OFS_DIVL, 8'h07);
      wr_reg(`SSR_OFS_IRQ, 8'h10);
      b0 = 8'($urandom);
      PAR.load({1'h0, b0}, 8);
      wr_reg(`SSR_OFS_RXSC, 8'hA0);
      wait_rx();
      rd_exp(`SSR_OFS_RXSC, 8'h80, 8'hFF, "single_done");
      rd_exp(`SSR_OFS_RXD, b0, 8'hFF, "rx_word");
      rd_exp(`SSR_OFS_IRQ, 8'h12, 8'hFF, "flag_clear");
      bad = 1'h0;
      for (int i = 0; i < 100; i++) begin
         @(posedge core_clk);
         if (ck_out !== 1'h0 || rx_irq !== 1'h0) bad = 1'h1;
      end
      check("clock_stopped", {8'h00, bad}, 9'h000);
      // Nine-bit words with both enables, then overrun
      do_reset();
      wr_reg(`SSR_OFS_TXSC, 8'h90);
      wr_reg(`SSR_OFS_DIVL, 8'h07);
      wr_reg(`SSR_OFS_IRQ, 8'h10);
      w0 = 9'($urandom) | 9'h100;
      w1 = 9'($urandom) & 9'h0FF;
      PAR.load(w0, 9);
      PAR.load(w1, 9);
      wr_reg(`SSR_OFS_RXSC, 8'hF0);
      wait_rx();
      rd_exp(`SSR_OFS_RXSC, 8'h01, 8'h01, "ninth_1");
      rd_exp(`SSR_OFS_RXD, w0[7:0], 8'hFF, "word_1");
      wait_rx();
      rd_exp(`SSR_OFS_RXSC, 8'h00, 8'h01, "ninth_2");
      rd_exp(`SSR_OFS_RXD, w1[7:0], 8'hFF, "word_2");
      repeat (450) @(posedge core_clk);
      rd_exp(`SSR_OFS_RXSC, 8'h02, 8'h02, "overrun");
      wr_reg(`SSR_OFS_RXSC, 8'h80);
      rd_exp(`SSR_OFS_RXSC, 8'h00, 8'h02, "overrun_clr");
      // Slave reception in low power
      do_reset();
      wr_reg(`SSR_OFS_TXSC, 8'h10);
      wr_reg(`SSR_OFS_RXSC, 8'hA0);
      low_power <= 1'h1;
      PAR.xfer(9'($urandom), 8, got);
      repeat (10) @(posedge core_clk);
      rd_exp(`SSR_OFS_IRQ, 8'h00, 8'h01, "single_ignored");
      wr_reg(`SSR_OFS_RXSC, 8'h90);
      b0 = 8'($urandom);
      PAR.xfer({1'h0, b0}, 8, got);
      repeat (10) @(posedge core_clk);
      check("rx_irq_off", {8'h00, rx_irq}, 9'h000);
      rd_exp(`SSR_OFS_IRQ, 8'h01, 8'h01, "slave_flag");
      rd_exp(`SSR_OFS_RXD, b0, 8'hFF, "slave_word");
      // Slave transmit of two queued words in low power
      do_reset();
      wr_reg(`SSR_OFS_TXSC, 8'h10);
      wr_reg(`SSR_OFS_RXSC, 8'h80);
      wr_reg(`SSR_OFS_IRQ, 8'h20);
      wr_reg(`SSR_OFS_TXSC, 8'h30);
      low_power <= 1'h1;
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      wr_reg(`SSR_OFS_TXD, b0);
      wr_reg(`SSR_OFS_TXD, b1);
      repeat (3) @(posedge core_clk);
      rd_exp(`SSR_OFS_IRQ, 8'h20, 8'h22, "tx_flag_clear");
      check("tx_irq_off", {8'h00, tx_irq}, 9'h000);
      check("dt_oe_n", {8'h00, dt_oe_n}, 9'h000);
      PAR.xfer(9'h000, 8, got);
      check("tx_word_1", got, {1'h0, b0});
      repeat (10) @(posedge core_clk);
      check("tx_irq_on", {8'h00, tx_irq}, 9'h001);
      PAR.xfer(9'h000, 8, got);
      check("tx_word_2", got, {1'h0, b1});
      repeat (5) @(posedge core_clk);
      print_verdict();
   end
endmodule // tb_top
